// ---- logic/dd_cfg.svh ----
// Constants for the decrement and divide execution unit.
// Assumes one core clock; the decoder and data memory share it.
`ifndef DD_CFG_SVH
`define DD_CFG_SVH

`define DD_OP_DEC_DIRECT 8'h15
`define DD_OP_DEC_IND    7'h0b
`define DD_OP_DIV_DFLT   8'hfe
`define DD_MC_CLKS_DFLT  4
`define DD_DEC_MC        1
`define DD_DIV_MC        4
`define DD_DIV_STEPS     4'h8
`define DD_ZERO_BYTE     8'h00
`define DD_ONE_BYTE      8'h01

`endif

// ---- logic/dd_divider.sv ----
// Restoring unsigned 8-bit divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse while the divider is idle.
`timescale 1ns/1ps
`include "dd_cfg.svh"

module dd_divider (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic [7:0] dividend,
	input  wire logic [7:0] divisor,
	output logic            done,
	output logic [7:0]      quotient,
	output logic [7:0]      remainder
);
	import dd_pkg::*;

	dd_div_t r;
	dd_div_t next_r;
	logic [8:0] trial;

	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		trial       = {r.rem, r.quo[7]};
		if (start) begin
			next_r.busy    = 1'b1;
			next_r.step    = 4'h0;
			next_r.divisor = divisor;
			next_r.quo     = dividend;
			next_r.rem     = `DD_ZERO_BYTE;
		end else if (r.busy) begin
			// Zero divisor falls through as all ones; caller flags it
			if (trial >= {1'b0, r.divisor}) begin
				next_r.rem = 8'(trial - {1'b0, r.divisor});
				next_r.quo = {r.quo[6:0], 1'b1};
			end else begin
				next_r.rem = trial[7:0];
				next_r.quo = {r.quo[6:0], 1'b0};
			end
			next_r.step = r.step + 4'h1;
			if (r.step == `DD_DIV_STEPS - 4'h1) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			r <= '0;
		else
			r <= next_r;
	end

	assign done      = r.done;
	assign quotient  = r.quo;
	assign remainder = r.rem;

endmodule : dd_divider

// ---- logic/dd_exec.sv ----
// Execution unit for memory decrement and unsigned accumulator divide.
// Assumes the decoder holds issue until ready, and the data memory
// returns read data one clock after a read strobe.
`timescale 1ns/1ps
`include "dd_cfg.svh"

module dd_exec #(
	parameter int         MC_CLKS    = `DD_MC_CLKS_DFLT,
	parameter logic [7:0] DIV_OPCODE = `DD_OP_DIV_DFLT
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire dd_pkg::dd_issue_t issue,
	output logic                   ready,
	output dd_pkg::dd_mem_req_t    mem,
	input  wire logic [7:0]        mem_rdata,
	output dd_pkg::dd_result_t     res
);
	import dd_pkg::*;

	// Whole machine cycles expressed in clocks
	localparam int DEC_N = `DD_DEC_MC * MC_CLKS;
	localparam int DIV_N = `DD_DIV_MC * MC_CLKS;

	function automatic dd_op_t op_kind(input logic [7:0] opc,
		input logic [7:0] div_opc);
		if (opc == `DD_OP_DEC_DIRECT)
			return DD_OP_DEC;
		else if (opc[7:1] == `DD_OP_DEC_IND)
			return DD_OP_DEC;
		else if (opc == div_opc)
			return DD_OP_DIV;
		else
			return DD_OP_NONE;
	endfunction : op_kind

	dd_exec_t   r;
	dd_exec_t   next_r;
	dd_op_t     kind;
	logic       accept;
	logic       div_start;
	logic       div_done;
	logic [7:0] div_quo;
	logic [7:0] div_rem;

	assign ready  = (r.st == DD_IDLE);
	assign kind   = op_kind(issue.opcode, DIV_OPCODE);
	// Unknown opcodes are never taken; the decoder sees ready stay high
	assign accept = issue.valid && ready && (kind != DD_OP_NONE);

	dd_divider u_div (
		.clk       (clk),
		.srst      (srst),
		.start     (div_start),
		.dividend  (issue.acc),
		.divisor   (issue.opb),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	always_comb begin
		next_r                = r;
		next_r.mem.rd         = 1'b0;
		next_r.mem.we         = 1'b0;
		next_r.res.done       = 1'b0;
		next_r.res.acc_we     = 1'b0;
		next_r.res.opb_we     = 1'b0;
		next_r.res.flag_we    = 1'b0;
		div_start             = 1'b0;
		case (r.st)
		DD_IDLE: begin
			if (accept) begin
				next_r.op = kind;
				if (kind == DD_OP_DIV) begin
					// Operands latched so the zero test sees the original
					next_r.dividend = issue.acc;
					next_r.divisor  = issue.opb;
					div_start       = 1'b1;
					next_r.st       = DD_DIVIDE;
					next_r.cnt      = 8'(DIV_N - 1);
				end else begin
					next_r.mem.rd = 1'b1;
					if (issue.opcode == `DD_OP_DEC_DIRECT)
						next_r.mem.addr = issue.operand;
					else if (issue.opcode[0])
						next_r.mem.addr = issue.ptr1;
					else
						next_r.mem.addr = issue.ptr0;
					next_r.st  = DD_READ;
					next_r.cnt = 8'(DEC_N - 1);
				end
			end
		end
		DD_READ: begin
			next_r.st = DD_MODIFY;
		end
		DD_MODIFY: begin
			// Wraps 00h to ffh by plain 8-bit arithmetic
			next_r.mem.we    = 1'b1;
			next_r.mem.wdata = mem_rdata - `DD_ONE_BYTE;
			next_r.st        = DD_HOLD;
		end
		DD_DIVIDE: begin
			if (div_done) begin
				next_r.res.acc = div_quo;
				next_r.res.opb = div_rem;
				next_r.st      = DD_HOLD;
			end
		end
		default: begin
			next_r.st = DD_HOLD;
		end
		endcase
		if (r.st != DD_IDLE) begin
			next_r.cnt = r.cnt - 8'h01;
			if (r.cnt == 8'h01) begin
				next_r.st       = DD_IDLE;
				next_r.res.done = 1'b1;
				if (r.op == DD_OP_DIV) begin
					next_r.res.acc_we        = 1'b1;
					next_r.res.opb_we        = 1'b1;
					next_r.res.flag_we       = 1'b1;
					next_r.res.carry_flag    = 1'b0;
					next_r.res.overflow_flag =
						(r.divisor == `DD_ZERO_BYTE);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r    <= '0;
			r.st <= DD_IDLE;
			r.op <= DD_OP_NONE;
		end else begin
			r <= next_r;
		end
	end

	assign mem = r.mem;
	assign res = r.res;

	// Helper: clocks since the instruction was taken
	logic [7:0] lat;
	logic [7:0] dec_addr;
	always_ff @(posedge clk) begin
		if (srst) begin
			lat      <= 8'h00;
			dec_addr <= 8'h00;
		end else if (accept) begin
			lat      <= 8'h01;
			dec_addr <= next_r.mem.addr;
		end else if (!ready) begin
			lat <= lat + 8'h01;
		end
	end

	a_dec_direct_addr: assert property (
		@(posedge clk) disable iff (srst)
		accept && issue.opcode == `DD_OP_DEC_DIRECT
		|=> mem.rd && mem.addr == $past(issue.operand))
		else $error("direct decrement read wrong address");

	a_dec_cycle_len: assert property (
		@(posedge clk) disable iff (srst)
		res.done && r.op == DD_OP_DEC |-> lat == 8'(DEC_N))
		else $error("decrement did not take one machine cycle");

	a_dec_write_back: assert property (
		@(posedge clk) disable iff (srst)
		mem.rd ##1 1'b1 ##1 mem.we |-> mem.addr == dec_addr
		&& mem.wdata == $past(mem_rdata) - `DD_ONE_BYTE)
		else $error("decrement wrote wrong value or address");

	// Completion and idle must coincide, and done is a single pulse
	a_done_ready: assert property (
		@(posedge clk) disable iff (srst)
		res.done |-> ready ##1 !res.done)
		else $error("done without ready or held too long");

	a_div_quot_rem: assert property (
		@(posedge clk) disable iff (srst)
		res.done && r.op == DD_OP_DIV && r.divisor != `DD_ZERO_BYTE
		|-> 16'(res.acc) * 16'(r.divisor) + 16'(res.opb)
			== 16'(r.dividend) && res.opb < r.divisor
		&& res.acc_we && res.opb_we)
		else $error("divide result does not satisfy quotient relation");

	a_div_cycle_len: assert property (
		@(posedge clk) disable iff (srst)
		res.done && r.op == DD_OP_DIV |-> lat == 8'(DIV_N))
		else $error("divide did not take four machine cycles");

	// Divide works on registers only; memory must stay quiet
	a_div_no_mem: assert property (
		@(posedge clk) disable iff (srst)
		r.op == DD_OP_DIV && !ready |-> !mem.rd && !mem.we)
		else $error("divide touched data memory");

	a_div_flag_clear: assert property (
		@(posedge clk) disable iff (srst)
		res.done && r.op == DD_OP_DIV && r.divisor != `DD_ZERO_BYTE
		|-> res.flag_we && !res.carry_flag && !res.overflow_flag)
		else $error("nonzero divide left carry or overflow set");

	a_div_zero_ovf: assert property (
		@(posedge clk) disable iff (srst)
		accept && kind == DD_OP_DIV && issue.opb == `DD_ZERO_BYTE
		|-> ##DIV_N res.done && res.flag_we
		&& res.overflow_flag && !res.carry_flag)
		else $error("zero divisor did not set overflow only");

	a_ind_ptr_flags: assert property (
		@(posedge clk) disable iff (srst)
		accept && issue.opcode[7:1] == `DD_OP_DEC_IND
		|=> mem.rd && mem.addr == ($past(issue.opcode[0]) ?
			$past(issue.ptr1) : $past(issue.ptr0))
		##[1:300] res.done && !res.flag_we)
		else $error("indirect decrement wrong pointer or touched flags");

	a_dec_flags_kept: assert property (
		@(posedge clk) disable iff (srst)
		res.done && r.op == DD_OP_DEC
		|-> !res.flag_we && !res.acc_we && !res.opb_we)
		else $error("decrement wrote flags or registers");

	c_dec_direct: cover property (@(posedge clk) disable iff (srst)
		accept && issue.opcode == `DD_OP_DEC_DIRECT);
	c_dec_ind_r0: cover property (@(posedge clk) disable iff (srst)
		accept && issue.opcode == {`DD_OP_DEC_IND, 1'b0});
	c_dec_ind_r1: cover property (@(posedge clk) disable iff (srst)
		accept && issue.opcode == {`DD_OP_DEC_IND, 1'b1});
	c_div_normal: cover property (@(posedge clk) disable iff (srst)
		res.done && r.op == DD_OP_DIV && !res.overflow_flag);
	c_div_zero: cover property (@(posedge clk) disable iff (srst)
		res.done && res.overflow_flag);

endmodule : dd_exec

// ---- logic/dd_pkg.sv ----
// Types for the decrement and divide execution unit.
// Assumes dd_cfg.svh supplies the numeric constants.
package dd_pkg;

	typedef enum logic [1:0] {DD_OP_NONE, DD_OP_DEC, DD_OP_DIV} dd_op_t;

	typedef enum logic [2:0] {
		DD_IDLE, DD_READ, DD_MODIFY, DD_DIVIDE, DD_HOLD
	} dd_st_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] opcode;
		logic [7:0] operand;
		logic [7:0] acc;
		logic [7:0] opb;
		logic [7:0] ptr0;
		logic [7:0] ptr1;
	} dd_issue_t;

	typedef struct packed {
		logic       rd;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dd_mem_req_t;

	typedef struct packed {
		logic       done;
		logic       acc_we;
		logic       opb_we;
		logic       flag_we;
		logic       carry_flag;
		logic       overflow_flag;
		logic [7:0] acc;
		logic [7:0] opb;
	} dd_result_t;

	typedef struct packed {
		logic       busy;
		logic       done;
		logic [3:0] step;
		logic [7:0] divisor;
		logic [7:0] quo;
		logic [7:0] rem;
	} dd_div_t;

	typedef struct packed {
		dd_st_t      st;
		dd_op_t      op;
		logic [7:0]  cnt;
		logic [7:0]  dividend;
		logic [7:0]  divisor;
		dd_mem_req_t mem;
		dd_result_t  res;
	} dd_exec_t;

endpackage : dd_pkg

// ---- tb/dd_exec_test.sv ----
// Self-checking bench for the decrement and divide unit.
// Assumes dd_mem_model stands in for the data memory.
`timescale 1ns/1ps

module dd_exec_test;
	import dd_pkg::*;

	localparam int         MC  = 4;
	localparam logic [7:0] DOP = 8'hfe;

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	dd_issue_t   issue = '0;
	logic        ready;
	dd_mem_req_t mem;
	logic [7:0]  mem_rdata;
	dd_result_t  res;
	int          mismatches = 0;
	int          total_checks = 0;

	dd_exec #(.MC_CLKS(MC), .DIV_OPCODE(DOP)) i_dd_exec (
		.clk(clk), .srst(srst), .issue(issue), .ready(ready),
		.mem(mem), .mem_rdata(mem_rdata), .res(res));

	dd_mem_model i_dd_mem_model (.clk(clk), .mem(mem), .rdata(mem_rdata));

	initial begin
		forever #2 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Presents one issue, then counts clocks to done; ready must stay low
	task automatic run(input logic [7:0] opc, opd, a, b, input int n);
		int cnt;
		@(posedge clk);
		issue <= '{1'b1, opc, opd, a, b, 8'h30, 8'h31};
		@(posedge clk);
		issue.valid <= 1'b0;
		for (cnt = 1; cnt < 40; cnt++) begin
			@(negedge clk);
			if (res.done === 1'b1)
				break;
			chk(8'(ready), 8'h00);
		end
		chk(8'(cnt), 8'(n));
		if (cnt == 40)
			end_sim();
	endtask : run

	task automatic test_reset();
		@(negedge clk);
		chk(8'(ready), 8'h01);
		chk({6'h00, mem.rd, mem.we}, 8'h00);
		chk(8'(res.done), 8'h00);
		$display("test reset done");
	endtask : test_reset

	task automatic test_dec_direct();
		i_dd_mem_model.ram[8'h40] = 8'h00;
		i_dd_mem_model.ram[8'h41] = 8'h80;
		run(8'h15, 8'h40, 8'h00, 8'h00, MC);
		chk(8'(res.flag_we), 8'h00);
		chk({6'h00, res.acc_we, res.opb_we}, 8'h00);
		run(8'h15, 8'h41, 8'h00, 8'h00, MC);
		chk(i_dd_mem_model.ram[8'h40], 8'hff);
		chk(i_dd_mem_model.ram[8'h41], 8'h7f);
		$display("test dec_direct done");
	endtask : test_dec_direct

	task automatic test_dec_ind();
		i_dd_mem_model.ram[8'h30] = 8'h40;
		i_dd_mem_model.ram[8'h31] = 8'h01;
		run(8'h16, 8'h00, 8'h00, 8'h00, MC);
		chk(i_dd_mem_model.ram[8'h30], 8'h3f);
		chk(i_dd_mem_model.ram[8'h31], 8'h01);
		run(8'h17, 8'h00, 8'h00, 8'h00, MC);
		chk(8'(res.flag_we), 8'h00);
		chk(i_dd_mem_model.ram[8'h31], 8'h00);
		$display("test dec_ind done");
	endtask : test_dec_ind

	task automatic test_div();
		logic [7:0] a [4] = '{8'hfb, 8'hff, 8'h07, 8'h00};
		logic [7:0] b [4] = '{8'h12, 8'h01, 8'h09, 8'h05};
		for (int i = 0; i < 4; i++) begin
			run(DOP, 8'h00, a[i], b[i], 4 * MC);
			chk(res.acc, a[i] / b[i]);
			chk(res.opb, a[i] % b[i]);
			chk({6'h00, res.acc_we, res.opb_we}, 8'h03);
			chk({6'h00, res.carry_flag, res.overflow_flag}, 8'h00);
			chk(8'(res.flag_we), 8'h01);
		end
		$display("test div done");
	endtask : test_div

	task automatic test_div_zero();
		run(DOP, 8'h00, 8'h23, 8'h00, 4 * MC);
		chk({6'h00, res.carry_flag, res.overflow_flag}, 8'h01);
		chk(8'(res.flag_we), 8'h01);
		$display("test div_zero done");
	endtask : test_div_zero

	// Reset in mid-divide must drop the work and leave the unit idle
	task automatic test_mid_reset();
		@(posedge clk);
		issue <= '{1'b1, DOP, 8'h00, 8'h64, 8'h07, 8'h30, 8'h31};
		@(posedge clk);
		issue.valid <= 1'b0;
		repeat (3) @(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk({5'h00, ready, mem.rd, res.done}, 8'h04);
		run(DOP, 8'h00, 8'h64, 8'h07, 4 * MC);
		chk(res.acc, 8'h0e);
		chk(res.opb, 8'h02);
		$display("test mid_reset done");
	endtask : test_mid_reset

	// An unknown opcode is never taken: no memory traffic, ready stays up
	task automatic test_bad_op();
		@(posedge clk);
		issue <= '{1'b1, 8'h00, 8'h40, 8'h00, 8'h00, 8'h30, 8'h31};
		repeat (6) begin
			@(negedge clk);
			chk({5'h00, ready, mem.rd, res.done}, 8'h04);
		end
		@(posedge clk);
		issue.valid <= 1'b0;
		$display("test bad_op done");
	endtask : test_bad_op

	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		test_reset();
		test_dec_direct();
		test_dec_ind();
		test_div();
		test_div_zero();
		test_mid_reset();
		test_bad_op();
		end_sim();
	end
endmodule : dd_exec_test

// ---- tb/dd_mem_model.sv ----
// Behavioural data memory facing the execution unit.
// Assumes one shared clock; read data valid one clock after a read.
`timescale 1ns/1ps

module dd_mem_model (
	input  wire logic                clk,
	input  wire dd_pkg::dd_mem_req_t mem,
	output logic [7:0]               rdata
);
	import dd_pkg::*;

	logic [7:0] ram [256];

	initial begin
		rdata = 8'h5a;
	end

	// Outside a read slot the bus flips every clock, so a sample taken one
	// clock late reads as the complement of the right byte.
	always @(posedge clk) begin
		if (mem.rd)
			rdata <= ram[mem.addr];
		else
			rdata <= ~rdata;
		if (mem.we)
			ram[mem.addr] <= mem.wdata;
	end
endmodule : dd_mem_model
